//--- src/par_defs.vh
// Register map, field positions, reset values and timing counts of the pulse accumulator.
`ifndef PAR_DEFS_VH
`define PAR_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PAR_OFS_CONTROL      8'h00
`define PAR_OFS_COUNT        8'h04
`define PAR_OFS_MASK2        8'h08
`define PAR_OFS_FLAGS2       8'h0C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define PAR_CTL_DIR7         7
`define PAR_CTL_ENABLE       6
`define PAR_CTL_MODE         5
`define PAR_CTL_EDGE         4
`define PAR_CTL_DIR3         3
`define PAR_CTL_IC4OC5       2
`define PAR_CTL_RATE_HI      1
`define PAR_CTL_RATE_LO      0

// ----------------------------------------------------------------------------
// Second timer mask and flag fields, shared bit positions
// ----------------------------------------------------------------------------
`define PAR_BIT_RTI          6
`define PAR_BIT_OVF          5
`define PAR_BIT_EDGE         4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PAR_RST_CONTROL      8'h00
`define PAR_RST_MASK2        3'h0
`define PAR_RST_FLAGS2       3'h0

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define PAR_CLK_PER_E        4
`define PAR_GATE_DIV         64
`define PAR_RTI_BASE_EXP     13
`define PAR_RTI_BASE_DIV     8192

`endif

//--- src/par_sync.v
// Two-stage synchroniser for a level that arrives from a pin.
`default_nettype none

module par_sync
(
  input  wire clk,     // System clock.
  input  wire rst_n,   // Asynchronous reset, active low.
  input  wire din,     // Asynchronous level.
  output reg  dout     // Synchronised level.
);

  reg stage1;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

`default_nettype wire

//--- src/par_tick_div.v
// Free-running divider that emits one enable pulse per DIV input pulses.
`default_nettype none

module par_tick_div
#(
  parameter integer DIV   = 64,  // Input pulses per output pulse.
  parameter integer WIDTH = 6    // Counter width, holds DIV-1.
)
(
  input  wire clk,     // System clock.
  input  wire rst_n,   // Asynchronous reset, active low.
  input  wire en,      // Input pulse.
  output reg  tick     // One-cycle output pulse.
);

  // The terminal count is cut to the counter width on purpose.
  localparam integer     LAST_INT = DIV - 1;
  localparam [WIDTH-1:0] LAST     = LAST_INT[WIDTH-1:0];

  reg [WIDTH-1:0] count;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end
    else
    begin
      tick <= en && (count == LAST);
      if (en)
      begin
        if (count == LAST)
          count <= {WIDTH{1'b0}};
        else
          count <= count + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- src/par_pulse_accum.v
// Pulse accumulator with real-time interrupt rate select, reached over APB.
//
// Contract
// - RTI base clock is E divided by 2^13.
// - Rate bits add division by 1, 2, 4, 8.
// - Eight-bit counter; mode bit picks events or gating.
// - Counting happens only while enable bit is set.
// - Gated mode counts E/64 ticks while pin active.
// - Event mode: edge bit picks falling or rising.
// - Gated mode: edge bit picks inhibiting level.
// - Pin feeds accumulator regardless of direction bit.
// - Count readable, writable anytime; reset keeps it.
// - Increments and reads fall in separate phases.
// - Overflow flag sets on wrap; write-one clears.
// - Overflow interrupt requested while flag and enable.
// - Edge flag sets on selected edge; write-one clears.
// - Edge interrupt requested while flag and enable.
// - Control bit selects capture four or compare five.
// - RTI period runs from previous timeout.
// - Writing flags with bit six clears RTI flag.
`include "par_defs.vh"
`default_nettype none

module par_pulse_accum
#(
  parameter integer CLK_PER_E    = `PAR_CLK_PER_E,     // System clocks per E cycle.
  parameter integer GATE_DIV     = `PAR_GATE_DIV,      // E cycles per gated count.
  parameter integer RTI_BASE_DIV = `PAR_RTI_BASE_DIV   // E cycles per RTI base tick.
)
(
  input  wire        clk,                  // System clock, 200 MHz.
  input  wire        rst_n,                // Asynchronous reset, active low.
  input  wire        psel,                 // APB select.
  input  wire        penable,              // APB enable.
  input  wire        pwrite,               // APB direction, high for write.
  input  wire [7:0]  paddr,                // APB byte address.
  input  wire [31:0] pwdata,               // APB write data.
  output reg  [31:0] prdata,               // APB read data.
  output wire        pready,               // APB ready.
  output wire        pslverr,              // APB error on unmapped address.
  input  wire        accumInputPin,        // Accumulator input pin level.
  output wire        portaBit7Dir,         // Port A bit 7 direction.
  output wire        portaBit3Dir,         // Port A bit 3 direction.
  output wire        capture4Compare5Sel,  // High selects capture channel four.
  output wire        accumOverflowIrq,     // Overflow interrupt request, level.
  output wire        accumEdgeIrq,         // Input-edge interrupt request, level.
  output wire        rtiIrq                // Real-time interrupt request, level.
);

  // --------------------------------------------------------------------------
  // Local constants
  // --------------------------------------------------------------------------
  localparam integer E_W    = 4;
  localparam integer GATE_W = 6;
  localparam integer BASE_W = `PAR_RTI_BASE_EXP;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg  [7:0] accumulator_control;
  reg  [7:0] accumulator_count;
  reg        rti_irq_en;
  reg        accum_overflow_irq_en;
  reg        accum_edge_irq_en;
  reg        rti_flag;
  reg        accum_overflow_flag;
  reg        accum_edge_flag;

  wire       accum_enable   = accumulator_control[`PAR_CTL_ENABLE];
  wire       accum_mode_sel = accumulator_control[`PAR_CTL_MODE];
  wire       accum_edge_sel = accumulator_control[`PAR_CTL_EDGE];
  wire       rti_rate_hi    = accumulator_control[`PAR_CTL_RATE_HI];
  wire       rti_rate_lo    = accumulator_control[`PAR_CTL_RATE_LO];

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire setupPhase  = psel && !penable;
  wire accessPhase = psel && penable;
  wire hitControl  = (paddr == `PAR_OFS_CONTROL);
  wire hitCount    = (paddr == `PAR_OFS_COUNT);
  wire hitMask     = (paddr == `PAR_OFS_MASK2);
  wire hitFlags    = (paddr == `PAR_OFS_FLAGS2);
  wire mapped      = hitControl || hitCount || hitMask || hitFlags;
  wire busWrite    = accessPhase && pwrite && mapped;

  assign pready  = 1'b1;
  assign pslverr = accessPhase && !mapped;

  // --------------------------------------------------------------------------
  // Time bases
  // --------------------------------------------------------------------------
  // All slower rates are enable pulses; the E tick plays the internal
  // phase two, so counter updates land one cycle after it while the bus samples its
  // read word a cycle earlier in the setup phase.
  wire eTick;
  wire gateTick;
  wire baseTick;

  par_tick_div
  #(
    .DIV   (CLK_PER_E),
    .WIDTH (E_W)
  )
  u_e_div
  (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (1'b1),
    .tick  (eTick)
  );

  par_tick_div
  #(
    .DIV   (GATE_DIV),
    .WIDTH (GATE_W)
  )
  u_gate_div
  (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (eTick),
    .tick  (gateTick)
  );

  // The base divider sees only E ticks, never a prescaled timer clock,
  // so the RTI rate does not move with any prescaler setting.
  par_tick_div
  #(
    .DIV   (RTI_BASE_DIV),
    .WIDTH (BASE_W)
  )
  u_rti_base
  (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (eTick),
    .tick  (baseTick)
  );

  // --------------------------------------------------------------------------
  // Real-time interrupt rate
  // --------------------------------------------------------------------------
  // The extra divider never resets on flag clearing, so every period is
  // measured from the previous timeout.
  reg  [2:0] rtiExtra;
  reg        rtiTimeout;
  reg  [2:0] rateMask;

  always @*
  begin
    case ({rti_rate_hi, rti_rate_lo})
      2'h0:    rateMask = 3'h0;
      2'h1:    rateMask = 3'h1;
      2'h2:    rateMask = 3'h3;
      2'h3:    rateMask = 3'h7;
      default: rateMask = 3'h0;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rtiExtra   <= 3'h0;
      rtiTimeout <= 1'b0;
    end
    else
    begin
      rtiTimeout <= baseTick && ((rtiExtra & rateMask) == rateMask);
      if (baseTick)
        rtiExtra <= rtiExtra + 3'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Accumulator input
  // --------------------------------------------------------------------------
  // The pin is taken straight from the pad, whatever the direction bit
  // says, so a driven output still counts its own transitions.
  wire pinSync;

  par_sync u_pin_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (accumInputPin),
    .dout  (pinSync)
  );

  // Sampling once per E cycle limits the useful input rate to E/2; a
  // faster source aliases and loses counts.
  reg pinNow;
  reg pinPrev;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinNow  <= 1'b0;
      pinPrev <= 1'b0;
    end
    else if (eTick)
    begin
      pinNow  <= pinSync;
      pinPrev <= pinNow;
    end
  end

  reg  eTickLate;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eTickLate <= 1'b0;
    else
      eTickLate <= eTick;
  end

  wire riseSeen    = eTickLate && pinNow && !pinPrev;
  wire fallSeen    = eTickLate && !pinNow && pinPrev;
  wire edgeSeen    = accum_edge_sel ? riseSeen : fallSeen;
  wire gateOpen    = pinNow ^ accum_edge_sel;

  reg  countStep;

  always @*
  begin
    countStep = 1'b0;
    if (accum_enable)
    begin
      if (accum_mode_sel)
        countStep = gateTick && gateOpen;
      else
        countStep = edgeSeen;
    end
  end

  wire countWrap = countStep && (accumulator_count == 8'hFF);

  // --------------------------------------------------------------------------
  // Count register
  // --------------------------------------------------------------------------
  // Deliberately outside the reset; it powers up unknown and keeps its
  // value through later resets. A bus write beats an increment.
  always @(posedge clk)
  begin
    if (busWrite && hitCount)
      accumulator_count <= pwdata[7:0];
    else if (countStep)
      accumulator_count <= accumulator_count + 8'h01;
  end

  // --------------------------------------------------------------------------
  // Control and mask registers
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accumulator_control   <= `PAR_RST_CONTROL;
      rti_irq_en            <= 1'b0;
      accum_overflow_irq_en <= 1'b0;
      accum_edge_irq_en     <= 1'b0;
    end
    else if (busWrite)
    begin
      if (hitControl)
        accumulator_control <= pwdata[7:0];
      if (hitMask)
      begin
        rti_irq_en            <= pwdata[`PAR_BIT_RTI];
        accum_overflow_irq_en <= pwdata[`PAR_BIT_OVF];
        accum_edge_irq_en     <= pwdata[`PAR_BIT_EDGE];
      end
    end
  end

  assign portaBit7Dir        = accumulator_control[`PAR_CTL_DIR7];
  assign portaBit3Dir        = accumulator_control[`PAR_CTL_DIR3];
  assign capture4Compare5Sel = accumulator_control[`PAR_CTL_IC4OC5];

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  // A flag that is set and cleared in the same cycle stays set, so an
  // event that races the service write is never lost.
  wire clrRti  = busWrite && hitFlags && pwdata[`PAR_BIT_RTI];
  wire clrOvf  = busWrite && hitFlags && pwdata[`PAR_BIT_OVF];
  wire clrEdge = busWrite && hitFlags && pwdata[`PAR_BIT_EDGE];
  wire setEdge = accum_enable && edgeSeen;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rti_flag            <= 1'b0;
      accum_overflow_flag <= 1'b0;
      accum_edge_flag     <= 1'b0;
    end
    else
    begin
      if (rtiTimeout)
        rti_flag <= 1'b1;
      else if (clrRti)
        rti_flag <= 1'b0;
      if (countWrap && !(busWrite && hitCount))
        accum_overflow_flag <= 1'b1;
      else if (clrOvf)
        accum_overflow_flag <= 1'b0;
      if (setEdge)
        accum_edge_flag <= 1'b1;
      else if (clrEdge)
        accum_edge_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt requests
  // --------------------------------------------------------------------------
  // Enables only gate the requests; the flags behave the same either way,
  // and a request stays up until its handler clears the flag.
  assign accumOverflowIrq = accum_overflow_flag && accum_overflow_irq_en;
  assign accumEdgeIrq     = accum_edge_flag && accum_edge_irq_en;
  assign rtiIrq           = rti_flag && rti_irq_en;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  reg [7:0] readByte;

  always @*
  begin
    readByte = 8'h00;
    case (paddr)
      `PAR_OFS_CONTROL:
        readByte = accumulator_control;
      `PAR_OFS_COUNT:
        readByte = accumulator_count;
      `PAR_OFS_MASK2:
      begin
        readByte[`PAR_BIT_RTI]  = rti_irq_en;
        readByte[`PAR_BIT_OVF]  = accum_overflow_irq_en;
        readByte[`PAR_BIT_EDGE] = accum_edge_irq_en;
      end
      `PAR_OFS_FLAGS2:
      begin
        readByte[`PAR_BIT_RTI]  = rti_flag;
        readByte[`PAR_BIT_OVF]  = accum_overflow_flag;
        readByte[`PAR_BIT_EDGE] = accum_edge_flag;
      end
      default:
        readByte = 8'h00;
    endcase
  end

  // Read data are captured in the setup phase and held through access.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (setupPhase && !pwrite)
      prdata <= {24'h000000, readByte};
  end

endmodule

`default_nettype wire

//--- verif/par_pulse_accum_checker.sv
// Port-level assertions for the pulse accumulator, bound to its top module.
`default_nettype none
module par_pulse_accum_checker
#(
  parameter int CLK_PER_E    = 4,    // System clocks per E cycle.
  parameter int GATE_DIV     = 64,   // E cycles per gated count.
  parameter int RTI_BASE_DIV = 8192  // E cycles per RTI base tick.
)
(
  input wire logic        clk,                  // System clock.
  input wire logic        rst_n,                // Reset, active low.
  input wire logic        psel,                 // APB select.
  input wire logic        penable,              // APB enable.
  input wire logic        pwrite,               // APB direction.
  input wire logic [7:0]  paddr,                // APB address.
  input wire logic [31:0] pwdata,               // APB write data.
  input wire logic [31:0] prdata,               // APB read data.
  input wire logic        pready,               // APB ready.
  input wire logic        pslverr,              // APB error.
  input wire logic        accumInputPin,        // Pin level.
  input wire logic        portaBit7Dir,         // Direction bit 7.
  input wire logic        portaBit3Dir,         // Direction bit 3.
  input wire logic        capture4Compare5Sel,  // Channel select.
  input wire logic        accumOverflowIrq,     // Overflow request.
  input wire logic        accumEdgeIrq,         // Edge request.
  input wire logic        rtiIrq                // RTI request.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Shadow of the control and mask registers, rebuilt from bus writes
  // ---------------------------------------------------------------------------
  // No RTI timeout can come sooner than one base period after reset, whatever the rate.
  localparam int RtiQuiet = RTI_BASE_DIV * CLK_PER_E - 4;
  logic [7:0]  ctl;
  logic [6:4]  msk;
  logic [15:0] sinceRst;
  wire         acc = psel && penable && pready;
  wire         wr  = acc && pwrite;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl      <= 8'h00;
      msk      <= 3'h0;
      sinceRst <= 16'h0000;
    end
    else
    begin
      if (wr && paddr == 8'h00) ctl <= pwdata[7:0];
      if (wr && paddr == 8'h08) msk <= pwdata[6:4];
      if (sinceRst != 16'hFFFF) sinceRst <= sinceRst + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Clear checks cover only flag writes made while counting is off, so no new set can race the clear.
  sequence s_flag_clear(int b); wr && paddr == 8'h0C && pwdata[b] && !ctl[6]; endsequence
  sequence s_read(logic [7:0] a); acc && !pwrite && paddr == a; endsequence

  property p_dir_outs;
    {portaBit7Dir, portaBit3Dir, capture4Compare5Sel} == {ctl[7], ctl[3], ctl[2]};
  endproperty
  a_dir_outs: assert property (p_dir_outs) else $error("direction output wrong");
  property p_ctl_read; s_read(8'h00) |-> prdata == {24'h000000, ctl}; endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read back wrong");
  property p_slverr; acc |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}); endproperty
  a_slverr: assert property (p_slverr) else $error("bus error flag wrong");
  property p_ovf_mask; !msk[5] |-> !accumOverflowIrq; endproperty
  a_ovf_mask: assert property (p_ovf_mask) else $error("overflow request while masked");
  property p_edge_mask; !msk[4] |-> !accumEdgeIrq; endproperty
  a_edge_mask: assert property (p_edge_mask) else $error("edge request while masked");
  property p_rti_mask; !msk[6] |-> !rtiIrq; endproperty
  a_rti_mask: assert property (p_rti_mask) else $error("RTI request while masked");
  property p_ovf_clear; s_flag_clear(5) |=> !accumOverflowIrq; endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");
  property p_edge_clear; s_flag_clear(4) |=> !accumEdgeIrq [*2]; endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");
  property p_edge_enable;
    $rose(accumEdgeIrq) && $past(msk[4]) |-> ctl[6] || $past(ctl[6]);
  endproperty
  a_edge_enable: assert property (p_edge_enable) else $error("edge flag while disabled");
  property p_rti_quiet; sinceRst < RtiQuiet |-> !rtiIrq; endproperty
  a_rti_quiet: assert property (p_rti_quiet) else $error("RTI timeout too early");
endmodule

bind par_pulse_accum par_pulse_accum_checker
#(.CLK_PER_E(CLK_PER_E), .GATE_DIV(GATE_DIV), .RTI_BASE_DIV(RTI_BASE_DIV))
i_par_pulse_accum_checker
(.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
 .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
 .accumInputPin(accumInputPin), .portaBit7Dir(portaBit7Dir), .portaBit3Dir(portaBit3Dir),
 .capture4Compare5Sel(capture4Compare5Sel), .accumOverflowIrq(accumOverflowIrq),
 .accumEdgeIrq(accumEdgeIrq), .rtiIrq(rtiIrq));
`default_nettype wire

//--- verif/par_pin_model.sv
// Model of the external pulse source that drives the accumulator input pin.
`default_nettype none
module par_pin_model
#(
  parameter int HOLD = 8  // Clocks each pin level is held.
)
(
  input  wire logic       clk,      // System clock.
  input  wire logic       start,    // Begin a burst of toggles.
  input  wire logic [3:0] toggles,  // Number of pin toggles in the burst.
  output var  logic       pinOut,   // Pin level.
  output wire logic       busy      // Burst in progress.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left = 4'h0;
  int         cnt  = 0;
  initial pinOut = 1'b0;
  assign busy = left != 4'h0;
  // Each level stands for at least one E period, so the pin never toggles faster than E/2.
  always @(posedge clk)
  begin
    if (start && !busy)
    begin
      left <= toggles;
      cnt  <= 0;
    end
    else if (busy && cnt == HOLD - 1)
    begin
      pinOut <= ~pinOut;
      left   <= left - 4'h1;
      cnt    <= 0;
    end
    else if (busy) cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

//--- verif/pulse_accumulator_rti_rate_test.sv
// Self-checking bench for the pulse accumulator with RTI rate select.
`default_nettype none
module pulse_accumulator_rti_rate_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Cpe  = 2;
  localparam int Gdiv = 4;
  localparam int Rdiv = 256;
  typedef struct { logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e; } par_row_t;
  par_row_t rows [0:4] = '{'{8'h00, 32'hFFFF_FF8F, 32'h0000_008F, 1'b0},
    '{8'h04, 32'h0000_015A, 32'h0000_005A, 1'b0}, '{8'h08, 32'h0000_00FF, 32'h0000_0070, 1'b0},
    '{8'h0C, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{8'h10, 32'h0000_00FF, 32'h0000_0000, 1'b1}};
  logic        clk;
  logic        rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  toggles = 4'h0;
  logic [31:0] pwdata = 32'h0, rdata;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin, dir7, dir3, chSel, ovfIrq, edgeIrq, rtiIrq, busy;
  int          failCount = 0, samplesChecked = 0, cycle = 0, t0, t1, t2, p;

  par_pulse_accum #(.CLK_PER_E(Cpe), .GATE_DIV(Gdiv), .RTI_BASE_DIV(Rdiv)) i_par_pulse_accum
  (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .accumInputPin(pin),
   .portaBit7Dir(dir7), .portaBit3Dir(dir3), .capture4Compare5Sel(chSel),
   .accumOverflowIrq(ovfIrq), .accumEdgeIrq(edgeIrq), .rtiIrq(rtiIrq));
  par_pin_model #(.HOLD(2 * Cpe)) i_par_pin_model
  (.clk(clk), .start(start), .toggles(toggles), .pinOut(pin), .busy(busy));

  // ---------------------------------------------------------------------------
  // Clock, cycle count, checking and bus tasks
  // ---------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycle <= cycle + 1;
    if (cycle == 30000)
    begin
      failCount++;
      completeRun();
    end
  end
  task completeRun();
    $display("checked %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task toggle(input int n);
    @(posedge clk);
    toggles <= 4'(n);
    start   <= 1'b1;
    @(posedge clk);
    start   <= 1'b0;
    do @(negedge clk); while (busy === 1'b1);
    repeat (Cpe + 6) @(negedge clk);
  endtask
  task doReset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t0 = cycle;
  endtask
  task waitRti(output int t);
    do @(negedge clk); while (rtiIrq !== 1'b1);
    t = cycle;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      check(32'(err), 32'(rows[i].e));
      apb(rows[i].a, 1'b0, 32'h0);
      check(rdata, rows[i].r);
      check(32'(err), 32'(rows[i].e));
    end
    check(32'({dir7, dir3, chSel}), 32'h7);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h30);
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h00, 32'h0);
      if (pin === 1'b1) toggle(1);
      wr(8'h0C, 32'h30);
      wr(8'h04, 32'hFE);
      wr(8'h00, 32'hC0 | 32'(e << 4));
      toggle(5);
      apb(8'h04, 1'b0, 32'h0);
      check(rdata, (e == 1) ? 32'h01 : 32'h00);
      apb(8'h0C, 1'b0, 32'h0);
      check(rdata & 32'h30, 32'h30);
      @(negedge clk);
      check({ovfIrq, edgeIrq}, 32'h3);
      wr(8'h00, 32'h0);
      wr(8'h0C, 32'h30);
      @(negedge clk);
      check({ovfIrq, edgeIrq}, 32'h0);
    end
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h77);
    toggle(4);
    apb(8'h04, 1'b0, 32'h0);
    check(rdata, 32'h77);
    check(32'(edgeIrq), 32'h0);
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h00, 32'h0);
      if (pin !== ~e[0]) toggle(1);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h60 | 32'(e << 4));
      repeat (10 * Gdiv * Cpe) @(posedge clk);
      apb(8'h04, 1'b0, 32'h0);
      check(32'(rdata >= 9 && rdata <= 12), 32'h1);
      toggle(1);
      wr(8'h04, 32'h0);
      repeat (10 * Gdiv * Cpe) @(posedge clk);
      apb(8'h04, 1'b0, 32'h0);
      check(rdata, 32'h0);
    end
    wr(8'h04, 32'h3C);
    doReset();
    apb(8'h04, 1'b0, 32'h0);
    check(rdata, 32'h3C);
    apb(8'h00, 1'b0, 32'h0);
    check(rdata, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      p = (Rdiv * Cpe) << r;
      doReset();
      wr(8'h00, 32'(r));
      wr(8'h08, 32'h40);
      waitRti(t1);
      check(32'(t1 - t0 >= p - 2 && t1 - t0 <= p + 4), 32'h1);
      wr(8'h0C, 32'h40);
      @(negedge clk);
      check(32'(rtiIrq), 32'h0);
      waitRti(t2);
      check(32'(t2 - t1), 32'(p));
    end
    completeRun();
  end
endmodule
`default_nettype wire
